// >>> rtl/erp_pkg.sv
package erp_pkg;

  // Upper four bits of a select byte that address the memory array.
  localparam logic [3:0] DEV_TYPE_ID = 4'hA;
  // Width of a data byte and of the byte address.
  localparam int         DATA_W      = 8;
  // Entries of the buffer between the memory and the shifter.
  localparam int         FIFO_DEPTH  = 2;
  // Bit counter value that marks the eighth bit of a byte.
  localparam logic [3:0] LAST_BIT    = 4'h8;
  // Reset value of the bit counter.
  localparam logic [3:0] BIT_RST     = 4'h0;
  // Bit counter value after the first data bit is driven.
  localparam logic [3:0] BIT_FIRST   = 4'h1;
  // Byte shifted out when the memory has not answered in time.
  localparam logic [7:0] IDLE_FILL   = 8'hFF;

  // Serial engine states.
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_DEVSEL  = 7'h02,
    ST_DEVACK  = 7'h04,
    ST_ADDR    = 7'h08,
    ST_ADDRACK = 7'h10,
    ST_TX      = 7'h20,
    ST_RXACK   = 7'h40
  } erp_state_t;

endpackage : erp_pkg

// >>> rtl/erp_stream_if.sv
`timescale 1ns/1ps
interface erp_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : erp_stream_if

// >>> rtl/erp_fifo.sv
`timescale 1ns/1ps
module erp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  erp_stream_if.snk s_in,
  erp_stream_if.src s_out
);
  import erp_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr;
    logic [PW-1:0]           rd;
    logic [PW:0]             cnt;
    logic                    in_rdy;
  } erp_fifo_st_t;

  erp_fifo_st_t q;
  erp_fifo_st_t n;
  logic         push;
  logic         pop;

  ////////////////////////////////////////////////////////////////////////////
  // Ready is registered so the filling side sees a clean level.
  assign s_in.ready  = q.in_rdy;
  assign s_out.valid = (q.cnt != '0);
  assign s_out.data  = q.mem[q.rd];

  // Next state: write at the write index, read at the read index.
  always_comb begin
    n    = q;
    push = s_in.valid & q.in_rdy;
    pop  = s_out.ready & (q.cnt != '0);
    if (push) begin
      n.mem[q.wr] = s_in.data;
      n.wr        = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + PW'(1);
    end
    if (pop) begin
      n.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + PW'(1);
    end
    case ({push, pop})
      2'b10:   n.cnt = q.cnt + (PW+1)'(1);
      2'b01:   n.cnt = q.cnt - (PW+1)'(1);
      default: n.cnt = q.cnt;
    endcase
    n.in_rdy = (n.cnt != (PW+1)'(DEPTH));
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      q        <= '0;
      q.in_rdy <= 1'b1;
    end else begin
      q <= n;
    end
  end

endmodule : erp_fifo

// >>> rtl/erp_read_path.sv
`timescale 1ns/1ps
module erp_read_path #(
  parameter int ADDR_W = erp_pkg::DATA_W
) (
  input  wire logic                       REF_CLK,
  input  wire logic                       RST,
  input  wire logic                       SCL,
  input  wire logic                       SDA_IN,
  output logic                            SDA_OUT,
  output logic                            SDA_OE,
  input  wire logic                       CHIP_SELECT_PIN_0,
  input  wire logic                       CHIP_SELECT_PIN_1,
  input  wire logic                       CHIP_SELECT_PIN_2,
  input  wire logic                       WRITE_PROTECT_INPUT,
  output logic                            MEM_REQ,
  output logic [ADDR_W-1:0]               MEM_ADDR,
  input  wire logic [erp_pkg::DATA_W-1:0] MEM_RDATA,
  input  wire logic                       MEM_RVALID,
  output logic                            MEM_RREADY
);
  import erp_pkg::*;

  typedef struct packed {
    logic [1:0]        scl_sync;
    logic [1:0]        sda_sync;
    logic [1:0][2:0]   cs_sync;
    logic              scl_p;
    logic              sda_p;
    erp_state_t        st;
    logic [3:0]        bit_cnt;
    logic [7:0]        shift;
    logic              rw;
    logic [ADDR_W-1:0] addr;
    logic              sda_oe;
    logic              sda_out;
    logic              mem_req;
    logic [ADDR_W-1:0] mem_addr;
  } erp_top_st_t;

  erp_top_st_t       q;
  erp_top_st_t       n;
  logic              scl_s;
  logic              sda_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              start;
  logic              stop;
  logic              id_match;
  logic              pop;
  logic [7:0]        byte_in;
  logic [ADDR_W-1:0] addr_inc;
  logic [ADDR_W-1:0] shift_addr;

  erp_stream_if #(.W(DATA_W)) mem_if ();
  erp_stream_if #(.W(DATA_W)) out_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Memory answers enter the two-entry buffer; its ready is a flop inside it.
  assign mem_if.valid = MEM_RVALID;
  assign mem_if.data  = MEM_RDATA;
  assign MEM_RREADY   = mem_if.ready;
  assign out_if.ready = pop;

  erp_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (REF_CLK),
    .rst   (RST),
    .s_in  (mem_if),
    .s_out (out_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions seen on the synchronised lines only.
  assign scl_s      = q.scl_sync[1];
  assign sda_s      = q.sda_sync[1];
  assign scl_rise   = scl_s & ~q.scl_p;
  assign scl_fall   = ~scl_s & q.scl_p;
  assign start      = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign stop       = scl_s & q.scl_p & ~q.sda_p & sda_s;
  assign id_match   = (q.shift[7:4] == DEV_TYPE_ID) && (q.shift[3:1] == q.cs_sync[1]);
  assign byte_in    = out_if.valid ? out_if.data : IDLE_FILL;
  assign addr_inc   = q.addr + ADDR_W'(1);
  assign shift_addr = ADDR_W'(q.shift);

  // Outputs come straight from the state register.
  assign SDA_OUT  = q.sda_out;
  assign SDA_OE   = q.sda_oe;
  assign MEM_REQ  = q.mem_req;
  assign MEM_ADDR = q.mem_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the serial engine.
  always_comb begin
    n          = q;
    pop        = 1'b0;
    n.scl_sync = {q.scl_sync[0], SCL};
    n.sda_sync = {q.sda_sync[0], SDA_IN};
    n.cs_sync  = {q.cs_sync[0], {CHIP_SELECT_PIN_2, CHIP_SELECT_PIN_1, CHIP_SELECT_PIN_0}};
    n.scl_p    = scl_s;
    n.sda_p    = sda_s;
    n.mem_req  = 1'b0;
    n.sda_out  = 1'b0;
    if (start) begin
      n.st      = ST_DEVSEL;
      n.bit_cnt = BIT_RST;
      n.sda_oe  = 1'b0;
    end else if (stop && (q.st != ST_TX)) begin
      n.st     = ST_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (q.st)
        ST_DEVSEL, ST_ADDR: begin
          if (scl_rise) begin
            n.shift   = {q.shift[6:0], sda_s};
            n.bit_cnt = q.bit_cnt + 4'h1;
          end
          if (scl_fall && (q.bit_cnt == LAST_BIT)) begin
            n.bit_cnt = BIT_RST;
            if (q.st == ST_ADDR) begin
              n.addr   = shift_addr;
              n.sda_oe = 1'b1;
              n.st     = ST_ADDRACK;
            end else if (id_match) begin
              // Direction bit alone picks the branch; write protect is not read.
              n.sda_oe = 1'b1;
              n.rw     = q.shift[0];
              n.st     = ST_DEVACK;
              if (q.shift[0]) begin
                n.mem_req  = 1'b1;
                n.mem_addr = q.addr;
              end
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
        ST_DEVACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              pop       = out_if.valid;
              n.shift   = byte_in;
              n.sda_oe  = ~byte_in[7];
              n.bit_cnt = BIT_FIRST;
              n.st      = ST_TX;
            end else begin
              n.sda_oe = 1'b0;
              n.st     = ST_ADDR;
            end
          end
        end
        ST_ADDRACK: begin
          // Only a repeated start continues from here.
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.st     = ST_IDLE;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (q.bit_cnt == LAST_BIT) begin
              n.sda_oe = 1'b0;
              n.addr   = addr_inc;
              n.st     = ST_RXACK;
            end else begin
              n.shift   = {q.shift[6:0], 1'b0};
              n.sda_oe  = ~q.shift[6];
              n.bit_cnt = q.bit_cnt + 4'h1;
            end
          end
        end
        ST_RXACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              n.st = ST_IDLE;
            end else begin
              n.mem_req  = 1'b1;
              n.mem_addr = q.addr;
            end
          end else if (scl_fall) begin
            pop       = out_if.valid;
            n.shift   = byte_in;
            n.sda_oe  = ~byte_in[7];
            n.bit_cnt = BIT_FIRST;
            n.st      = ST_TX;
          end
        end
        default: begin
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register; lines idle high from reset.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.scl_sync <= 2'h3;
      q.sda_sync <= 2'h3;
      q.scl_p    <= 1'b1;
      q.sda_p    <= 1'b1;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the engine.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // A matching read select is acknowledged and then leads into transmission.
  sequence s_select_ack;
    (q.st == ST_DEVACK) && q.sda_oe && q.rw && scl_fall;
  endsequence
  property p_select_to_tx;
    s_select_ack |=> (q.st == ST_TX) && (q.bit_cnt == BIT_FIRST);
  endproperty
  a_select_to_tx: assert property (p_select_to_tx) else $error("read select not followed by data");

  property p_ack_driven;
    (q.st == ST_DEVACK) |-> q.sda_oe;
  endproperty
  a_ack_driven: assert property (p_ack_driven) else $error("select ack not driven");

  property p_deselect;
    ((q.st == ST_DEVSEL) && scl_fall && (q.bit_cnt == LAST_BIT) && !id_match)
      |=> (q.st == ST_IDLE) && !q.sda_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("mismatched select not ignored");

  property p_addr_load;
    ((q.st == ST_ADDR) && scl_fall && (q.bit_cnt == LAST_BIT)) |=> (q.addr == $past(shift_addr));
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address byte not loaded");

  property p_addr_step;
    ((q.st == ST_TX) && scl_fall && (q.bit_cnt == LAST_BIT)) |=> (q.addr == $past(addr_inc));
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("counter not incremented");

  property p_addr_wrap;
    ((q.st == ST_TX) && scl_fall && (q.bit_cnt == LAST_BIT) && (&q.addr)) |=> (q.addr == '0);
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("counter did not wrap");

  property p_ack_released;
    (q.st == ST_RXACK) |-> !q.sda_oe;
  endproperty
  a_ack_released: assert property (p_ack_released) else $error("line held in ack slot");

  property p_noack_standby;
    ((q.st == ST_RXACK) && scl_rise && sda_s) |=> (q.st == ST_IDLE) ##1 !q.sda_oe;
  endproperty
  a_noack_standby: assert property (p_noack_standby) else $error("no standby after NoAck");

  // An acknowledge asks for the next byte and sends it within 400 reference clock cycles.
  sequence s_master_ack;
    (q.st == ST_RXACK) && scl_rise && !sda_s && !start && !stop;
  endsequence
  sequence s_next_byte;
    q.mem_req ##[1:400] (q.st == ST_TX);
  endsequence
  property p_seq_continue;
    s_master_ack |=> s_next_byte;
  endproperty
  a_seq_continue: assert property (p_seq_continue) else $error("sequential read stalled");

  property p_low_change;
    $changed(q.sda_oe) |-> !$past(scl_s);
  endproperty
  a_low_change: assert property (p_low_change) else $error("data changed with clock high");

  property p_stop_in_tx;
    ((q.st == ST_TX) && stop) |=> (q.st == ST_TX);
  endproperty
  a_stop_in_tx: assert property (p_stop_in_tx) else $error("stop mid byte forced standby");

endmodule : erp_read_path

// >>> tb/erp_master_model.sv
`timescale 1ns/1ps
// Behavioural bus master that drives the serial clock and pulls or releases the data wire.
module erp_master_model (
  output logic     scl,
  output logic     sda_rel,
  input  wire logic sda
);
  // A quarter of the 64 ns serial clock period.
  localparam int Q = 16;

  // The bus idles with the clock high and the data wire released.
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // One bit slot: data changes while the clock is low, the wire is read mid high phase.
  task automatic bit_x(input logic b, output logic r);
    sda_rel = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_x

  // Start or repeated start: the data wire falls while the clock is high.
  task automatic start();
    sda_rel = 1'b1;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start

  // Stop: the data wire rises while the clock is high, then the bus rests.
  task automatic stop();
    sda_rel = 1'b0;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b1;
    #(2*Q);
  endtask : stop

  // Sends a byte most significant bit first and returns the wire level of the ack slot.
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, ack);
  endtask : wr_byte

  // Reads a byte, then acks it or leaves the ninth slot released.
  task automatic rd_byte(input logic mack, output logic [7:0] d, output logic lvl);
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(!mack, lvl);
  endtask : rd_byte
endmodule : erp_master_model

// >>> tb/test_serial_eeprom_read_path.sv
`timescale 1ns/1ps
module test_serial_eeprom_read_path;
  import erp_pkg::*;
  logic        ref_clk, rst, wp, mem_rvalid, sda_oe, sda_out, mem_req, mem_rready, ack, lvl;
  logic [2:0]  pins;
  logic [7:0]  mem_rdata, mem_addr, d;
  logic [7:0]  mem [256];
  logic [31:0] seed;
  logic [7:0]  exp_q [$];
  wire logic   scl, sda_rel, sda;
  int          n_fail, n_tests, cyc, cnt;

  // The data wire is pulled up and pulled low by either party.
  assign sda = sda_rel & ~(sda_oe & ~sda_out);

  erp_master_model u_mst (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  erp_read_path u_dut (
    .REF_CLK(ref_clk), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .CHIP_SELECT_PIN_0(pins[0]), .CHIP_SELECT_PIN_1(pins[1]),
    .CHIP_SELECT_PIN_2(pins[2]), .WRITE_PROTECT_INPUT(wp), .MEM_REQ(mem_req),
    .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata), .MEM_RVALID(mem_rvalid),
    .MEM_RREADY(mem_rready)
  );

  // Clock of 5 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Memory answers a request one cycle later and scrambles its data once taken.
  // Reset is sampled at the edge itself, so its release one step later cannot race.
  always @(posedge ref_clk) begin
    logic       took;
    logic       req;
    logic       clr;
    logic [7:0] a;
    took = mem_rvalid & mem_rready;
    req  = mem_req;
    clr  = rst;
    a    = mem_addr;
    #1;
    if (clr) begin
      mem_rvalid = 1'b0;
      mem_rdata  = 8'h00;
    end else begin
      if (took) begin
        mem_rvalid = 1'b0;
        mem_rdata  = ~mem_rdata;
      end
      if (req) begin
        mem_rvalid = 1'b1;
        mem_rdata  = mem[a];
      end
    end
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      $display("[ERR] run length exp finish got hang");
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Xorshift source for random stimulus.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Select byte with the given chip select field and read flag.
  function automatic logic [7:0] sel(input logic [2:0] cs, input logic rd);
    return {DEV_TYPE_ID, cs, rd};
  endfunction : sel

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Reads n bytes from the model counter, acking all but the last.
  task automatic read_n(input int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[cnt]);
      u_mst.rd_byte(i < n - 1, d, lvl);
      chk("data", exp_q.pop_front(), d);
      if (i == n - 1) chk("ack slot", 8'h01, {7'h00, lvl});
      cnt = (cnt + 1) % 256;
    end
  endtask : read_n

  // Dummy write of the address, repeated start, then a read of n bytes.
  task automatic rand_read(input logic [7:0] a, input int n);
    u_mst.start();
    u_mst.wr_byte(sel(pins, 1'b0), ack);
    chk("wsel ack", 8'h00, {7'h00, ack});
    u_mst.wr_byte(a, ack);
    chk("addr ack", 8'h00, {7'h00, ack});
    u_mst.start();
    u_mst.wr_byte(sel(pins, 1'b1), ack);
    chk("rsel ack", 8'h00, {7'h00, ack});
    cnt = a;
    read_n(n);
    u_mst.stop();
  endtask : rand_read

  // Start and read select only, then n bytes from the counter.
  task automatic cur_read(input int n, input logic stp);
    u_mst.start();
    u_mst.wr_byte(sel(pins, 1'b1), ack);
    chk("csel ack", 8'h00, {7'h00, ack});
    read_n(n);
    if (stp) u_mst.stop();
  endtask : cur_read

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed = 32'h0f420537;
    rst = 1'b1;
    wp = 1'b0;
    pins = 3'h5;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(rnd());
    end
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    rand_read(8'h3C, 1);
    cur_read(1, 1'b1);
    cur_read(2, 1'b1);
    $display("test random and current read done");
    rand_read(8'hFE, 4);
    $display("test wrap done");
    // The same read with both write protect levels.
    for (int w = 0; w < 2; w++) begin
      @(posedge ref_clk);
      #1 wp = w[0];
      rand_read(8'h80, 2);
    end
    $display("test write protect done");
    // Random straps, protect level, address and length.
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      #1 pins = 3'(rnd());
      wp = 1'(rnd());
      repeat (4) @(posedge ref_clk);
      if (rnd() & 1) rand_read(8'(rnd()), 1 + int'(rnd() % 3));
      else cur_read(1 + int'(rnd() % 3), 1'b1);
    end
    $display("test random mix done");
    // Wrong chip select bits and a wrong type field get no answer.
    for (int i = 0; i < 4; i++) begin
      u_mst.start();
      u_mst.wr_byte(i < 3 ? sel(pins ^ (3'b001 << i), 1'b1) : {4'h5, pins, 1'b1}, ack);
      chk("foreign ack", 8'h01, {7'h00, ack});
      u_mst.rd_byte(1'b0, d, lvl);
      chk("foreign data", 8'hFF, d);
      u_mst.stop();
    end
    $display("test select mismatch done");
    // A STOP while the first bit is on the wire is ignored and the byte runs on.
    // The top bit is forced to one so that the released wire can rise.
    mem[cnt][7] = 1'b1;
    u_mst.start();
    u_mst.wr_byte(sel(pins, 1'b1), ack);
    chk("msel ack", 8'h00, {7'h00, ack});
    u_mst.stop();
    u_mst.rd_byte(1'b0, d, lvl);
    chk("stop mid byte", mem[cnt], d);
    cnt = (cnt + 1) % 256;
    u_mst.stop();
    $display("test stop in byte done");
    // After a NoAck the device keeps off the wire, and the counter carries on.
    cur_read(1, 1'b0);
    u_mst.rd_byte(1'b0, d, lvl);
    chk("standby data", 8'hFF, d);
    u_mst.stop();
    cur_read(2, 1'b1);
    $display("test standby done");
    give_verdict();
  end
endmodule : test_serial_eeprom_read_path
